//--- rtl/pgc_map.svh
// Register map, field positions, reset values and timing counts for the
// general control and collision statistics bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses of four times an index.
`ifndef PGC_MAP_SVH
`define PGC_MAP_SVH

// Register indices, byte address is four times the index
`define PGC_IDX_GENCTL 8'h14
`define PGC_IDX_LC_LO 8'h17
`define PGC_IDX_LC_HI 8'h18
`define PGC_IDX_WIN 8'h19
`define PGC_IDX_IRQ_STAT 8'h1A
`define PGC_IDX_IRQ_EN 8'h1B
`define PGC_IDX_IRQ_CLR 8'h1C

// General control fields
`define PGC_GC_RST_BIT 15
`define PGC_GC_SNOOP_LSB 10
`define PGC_GC_MEDIA_LSB 4
`define PGC_GC_MODE_LSB 0
`define PGC_MODE_SGMII_CU 3'h1
`define PGC_SNOOP_NET 2'h2
`define PGC_SNOOP_MAC 2'h3
`define PGC_MEDIA_COPPER 2'h1

// Window register fields and reset values
`define PGC_WIN_ADJ_LSB 8
`define PGC_WIN_ADJ_RST 5'h00
`define PGC_CNT_RST 8'h00

// First transmit byte of each bin with zero adjustment
`define PGC_BIN0_START 12'h041
`define PGC_BIN1_START 12'h061
`define PGC_BIN2_START 12'h081
`define PGC_BIN3_START 12'h0C1

// Software reset pulse, in core clock cycles
`define PGC_SWRST_CYCLES 4

// Interrupt status bits: 0..3 bins, 4 link drop, 5 reset done
`define PGC_IRQ_W 6
`define PGC_IRQ_LDROP 4
`define PGC_IRQ_RSTDONE 5

// Avalon response codes
`define PGC_RESP_OK 2'h0
`define PGC_RESP_DECERR 2'h3

`endif

//--- rtl/pgc_pkg.sv
// Types shared by the general control and collision statistics bank.
// Assumes pgc_map.svh for all numeric constants.
package pgc_pkg;

    // Software reset sequencer, one-hot
    typedef enum logic [1:0] {
        PGC_RST_IDLE = 2'b01,
        PGC_RST_BUSY = 2'b10
    } pgc_rst_e;

    typedef logic [2:0] pgc_mode_t;
    typedef logic [11:0] pgc_pos_t;

endpackage

//--- rtl/pgc_regs.sv
// General control and late-collision statistics register bank.
// Assumes GMII-side inputs come from logic on i_core_clk; the mode straps
// are pins and are synchronised here.
`timescale 1ns/10ps
`include "pgc_map.svh"

module pgc_regs
    import pgc_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int SWRST_CYC = `PGC_SWRST_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic [1:0] o_avs_response,
    output logic o_avs_waitrequest,
    // Internal GMII observation
    input wire logic i_half_duplex,
    input wire logic i_gmii_tx_en,
    input wire logic i_gmii_rx_dv,
    input wire logic i_link_up,
    // Mode straps
    input wire logic [2:0] i_mode_pins,
    // Control outputs
    output logic o_phy_sm_rst,
    output logic [2:0] o_sys_mode,
    output logic o_mode_sgmii_cu,
    output logic o_snoop_net,
    output logic o_snoop_mac,
    output logic o_copper_pref,
    output logic o_irq
);

    // Elaboration checks; counts read back through 8-bit fields
    generate
        if (CNT_W < 1 || CNT_W > 8 || SWRST_CYC < 1 || SWRST_CYC > 255) begin : g_bad_param
            $error("CNT_W must be 1 to 8 and SWRST_CYC 1 to 255");
        end
    endgenerate

    localparam int NB = 4;
    logic ack, req, take;
    logic [7:0] idx;
    logic hit_gc, hit_lo, hit_hi, hit_win, hit_st, hit_en, hit_clr, mapped;
    logic [1:0] snoop, media;
    pgc_mode_t mode_wr;
    logic [4:0] win_adj;
    pgc_rst_e rst_st;
    logic [7:0] rst_cnt;
    logic [2:0] mode_s1, mode_s2, mode_s3;
    logic strap_pend, rx_dv_q, link_q, sop, ldrop, swrst_go, swrst_done;
    pgc_pos_t tx_pos, cur;
    pgc_pos_t bnd [NB+1];
    logic [NB-1:0] bin_hit;
    logic [CNT_W-1:0] lc_cnt [NB];
    logic [CNT_W-1:0] ld_cnt;
    logic [`PGC_IRQ_W-1:0] irq_stat, irq_en, irq_ev, irq_clr;
    logic [15:0] rd_mux;

    // Decode; only word-aligned addresses are mapped
    assign idx = i_avs_address[9:2];
    assign req = i_avs_read | i_avs_write;
    assign take = req & ack;
    always_comb begin
        {hit_gc, hit_lo, hit_hi, hit_win, hit_st, hit_en, hit_clr} = 7'h00;
        if (i_avs_address[1:0] != 2'b00) begin
            hit_gc = 1'b0;
        end else if (idx == `PGC_IDX_GENCTL) begin
            hit_gc = 1'b1;
        end else if (idx == `PGC_IDX_LC_LO) begin
            hit_lo = 1'b1;
        end else if (idx == `PGC_IDX_LC_HI) begin
            hit_hi = 1'b1;
        end else if (idx == `PGC_IDX_WIN) begin
            hit_win = 1'b1;
        end else if (idx == `PGC_IDX_IRQ_STAT) begin
            hit_st = 1'b1;
        end else if (idx == `PGC_IDX_IRQ_EN) begin
            hit_en = 1'b1;
        end else if (idx == `PGC_IDX_IRQ_CLR) begin
            hit_clr = 1'b1;
        end
    end
    assign mapped = hit_gc | hit_lo | hit_hi | hit_win | hit_st | hit_en | hit_clr;

    // One wait cycle per access so read data stands in a flop
    assign o_avs_waitrequest = req & ~ack;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // Read mux, upper half reads zero
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_gc) begin
            rd_mux[`PGC_GC_RST_BIT] = (rst_st == PGC_RST_BUSY);
            rd_mux[`PGC_GC_SNOOP_LSB +: 2] = snoop;
            rd_mux[`PGC_GC_MEDIA_LSB +: 2] = media;
            rd_mux[`PGC_GC_MODE_LSB +: 3] = mode_wr;
        end else if (hit_lo) begin
            rd_mux[7:0] = 8'(lc_cnt[0]);
            rd_mux[15:8] = 8'(lc_cnt[1]);
        end else if (hit_hi) begin
            rd_mux[7:0] = 8'(lc_cnt[2]);
            rd_mux[15:8] = 8'(lc_cnt[3]);
        end else if (hit_win) begin
            rd_mux[`PGC_WIN_ADJ_LSB +: 5] = win_adj;
            rd_mux[7:0] = 8'(ld_cnt);
        end else if (hit_st) begin
            rd_mux[`PGC_IRQ_W-1:0] = irq_stat;
        end else if (hit_en) begin
            rd_mux[`PGC_IRQ_W-1:0] = irq_en;
        end
    end

    // Read data and response captured in the wait cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= `PGC_RESP_OK;
        end else if (req && !ack) begin
            o_avs_readdata <= {16'h0000, rd_mux};
            o_avs_response <= mapped ? `PGC_RESP_OK : `PGC_RESP_DECERR;
        end
    end

    // Control fields written by software
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            snoop <= 2'h0;
            media <= 2'h0;
            win_adj <= `PGC_WIN_ADJ_RST;
        end else if (take && i_avs_write) begin
            if (hit_gc && i_avs_byteenable[1]) begin
                snoop <= i_avs_writedata[`PGC_GC_SNOOP_LSB +: 2];
            end
            if (hit_gc && i_avs_byteenable[0]) begin
                media <= i_avs_writedata[`PGC_GC_MEDIA_LSB +: 2];
            end
            if (hit_win && i_avs_byteenable[1]) begin
                win_adj <= i_avs_writedata[`PGC_WIN_ADJ_LSB +: 5];
            end
        end
    end

    // Strap synchroniser, not reset so it tracks the pins during reset
    always_ff @(posedge i_core_clk) begin
        mode_s1 <= i_mode_pins;
        mode_s2 <= mode_s1;
        mode_s3 <= mode_s2;
    end

    // Mode field: strap after hardware reset, software writes later
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mode_wr <= 3'h0;
            strap_pend <= 1'b1;
        end else if (strap_pend) begin
            if (mode_s2 == mode_s3) begin
                mode_wr <= mode_s3;
                strap_pend <= 1'b0;
            end
        end else if (take && i_avs_write && hit_gc && i_avs_byteenable[0]) begin
            mode_wr <= i_avs_writedata[`PGC_GC_MODE_LSB +: 3];
        end
    end

    // A one in bit 15 starts the reset in the same edge the write lands
    assign swrst_go = take && i_avs_write && hit_gc && i_avs_byteenable[1] && i_avs_writedata[`PGC_GC_RST_BIT];
    // Software reset sequencer
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rst_st <= PGC_RST_IDLE;
            rst_cnt <= 8'h00;
        end else begin
            case (rst_st)
                PGC_RST_IDLE: begin
                    if (swrst_go) begin
                        rst_st <= PGC_RST_BUSY;
                        rst_cnt <= 8'(SWRST_CYC - 1);
                    end
                end
                PGC_RST_BUSY: begin
                    if (rst_cnt == 8'h00) begin
                        rst_st <= PGC_RST_IDLE;
                    end else begin
                        rst_cnt <= rst_cnt - 8'h01;
                    end
                end
                default: begin
                    rst_st <= PGC_RST_IDLE;
                end
            endcase
        end
    end
    assign swrst_done = (rst_st == PGC_RST_BUSY) && (rst_cnt == 8'h00);
    assign o_phy_sm_rst = (rst_st == PGC_RST_BUSY);

    // Effective mode changes only with a reset, avoiding a live switch
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_sys_mode <= 3'h0;
        end else if (strap_pend && mode_s2 == mode_s3) begin
            o_sys_mode <= mode_s3;
        end else if (swrst_go) begin
            o_sys_mode <= mode_wr;
        end
    end
    assign o_mode_sgmii_cu = (o_sys_mode == `PGC_MODE_SGMII_CU);

    // Decoded selects; reserved codes select nothing
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_snoop_net <= 1'b0;
            o_snoop_mac <= 1'b0;
            o_copper_pref <= 1'b0;
        end else begin
            o_snoop_net <= (snoop == `PGC_SNOOP_NET);
            o_snoop_mac <= (snoop == `PGC_SNOOP_MAC);
            o_copper_pref <= (media == `PGC_MEDIA_COPPER);
        end
    end

    // Edge history on the internal GMII and link status
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rx_dv_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            rx_dv_q <= i_gmii_rx_dv;
            link_q <= i_link_up;
        end
    end
    assign sop = i_gmii_rx_dv & ~rx_dv_q;
    assign ldrop = link_q & ~i_link_up;
    // Transmit byte position, saturating so long frames stay in bin four
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_pos <= 12'h000;
        end else if (!i_gmii_tx_en) begin
            tx_pos <= 12'h000;
        end else if (tx_pos != 12'hFFE) begin
            tx_pos <= tx_pos + 12'h001;
        end
    end
    assign cur = tx_pos + 12'h001;

    // Bin starts all pulled earlier by the window adjust; the top bound bnd[4] stays fixed
    assign bnd[0] = `PGC_BIN0_START - {7'h00, win_adj};
    assign bnd[1] = `PGC_BIN1_START - {7'h00, win_adj};
    assign bnd[2] = `PGC_BIN2_START - {7'h00, win_adj};
    assign bnd[3] = `PGC_BIN3_START - {7'h00, win_adj};
    assign bnd[4] = 12'hFFF;
    // Per-bin hit and saturating, clear-on-read counter
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_bin
            logic rd_clr;
            // Bins 0 and 1 share the low register, 2 and 3 the high one
            assign rd_clr = take && i_avs_read && ((gi < 2) ? hit_lo : hit_hi);
            assign bin_hit[gi] = sop && i_gmii_tx_en && i_half_duplex && cur >= bnd[gi] && (gi == NB-1 || cur < bnd[gi+1]);
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    lc_cnt[gi] <= '0;
                end else if (rd_clr) begin
                    // A hit in the clearing cycle survives as one
                    lc_cnt[gi] <= bin_hit[gi] ? CNT_W'(1) : '0;
                end else if (bin_hit[gi] && !(&lc_cnt[gi])) begin
                    lc_cnt[gi] <= lc_cnt[gi] + CNT_W'(1);
                end
            end
        end
    endgenerate

    // Link-drop counter
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ld_cnt <= '0;
        end else if (take && i_avs_read && hit_win) begin
            ld_cnt <= ldrop ? CNT_W'(1) : '0;
        end else if (ldrop && !(&ld_cnt)) begin
            ld_cnt <= ld_cnt + CNT_W'(1);
        end
    end

    // Interrupt status: set wins over a clear in the same cycle
    assign irq_ev = {swrst_done, ldrop, bin_hit};
    assign irq_clr = (take && i_avs_write && hit_clr && i_avs_byteenable[0]) ? i_avs_writedata[`PGC_IRQ_W-1:0] : '0;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_stat <= '0;
            irq_en <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            if (take && i_avs_write && hit_en && i_avs_byteenable[0]) begin
                irq_en <= i_avs_writedata[`PGC_IRQ_W-1:0];
            end
        end
    end
    assign o_irq = |(irq_stat & irq_en);

    // Assertions
    swrst_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        swrst_go && rst_st == PGC_RST_IDLE |=> o_phy_sm_rst)
        else $error("software reset did not start at once");
    swrst_len_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(o_phy_sm_rst) |-> o_phy_sm_rst [*4] ##1 !o_phy_sm_rst)
        else $error("software reset pulse length wrong");
    swrst_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(o_phy_sm_rst) |-> ##[1:300] (rst_st == PGC_RST_IDLE))
        else $error("reset bit never cleared");
    mode_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !strap_pend && !swrst_go |=> $stable(o_sys_mode))
        else $error("mode changed without a software reset");
    mode_strap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        strap_pend && mode_s2 == mode_s3 |=> mode_wr == $past(mode_s3))
        else $error("mode did not load from straps");
    mode_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_mode_sgmii_cu |-> o_sys_mode == 3'h1)
        else $error("reserved mode decoded as valid");
    snoop_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ##1 o_snoop_mac == ($past(snoop) == 2'h3) && !(o_snoop_mac && o_snoop_net))
        else $error("snoop select wrong");
    media_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ##1 o_copper_pref == ($past(media) == 2'h1))
        else $error("media select wrong");
    bin0_count_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        bin_hit[0] && !(take && i_avs_read && hit_lo) && !(&lc_cnt[0])
        |=> lc_cnt[0] == $past(lc_cnt[0]) + CNT_W'(1))
        else $error("first bin did not count");
    bin_win_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        sop && i_gmii_tx_en && i_half_duplex && cur == 12'd65 - {7'h00, win_adj}
        |-> bin_hit[0])
        else $error("window start misplaced");
    bin_last_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        bin_hit[3] |-> cur >= 12'd193 - {7'h00, win_adj})
        else $error("fourth bin hit too early");
    bin_duplex_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !i_half_duplex |-> bin_hit == '0)
        else $error("collision counted in full duplex");
    cnt_sat_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (&ld_cnt) && !(take && i_avs_read && hit_win) |=> (&ld_cnt))
        else $error("link-drop counter wrapped");
    cnt_rdclr_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_avs_read && hit_win && !ldrop |=> ld_cnt == '0)
        else $error("link-drop counter not cleared by read");
    ldrop_cnt_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ldrop && !(take && i_avs_read && hit_win) && !(&ld_cnt)
        |=> ld_cnt == $past(ld_cnt) + CNT_W'(1))
        else $error("link drop not counted");

endmodule

//--- tb/pgc_mac_model.sv
// MAC-side traffic source seen on the internal GMII of the stats bank.
// Assumes the bench pulses i_start for one cycle and waits for o_busy low.
`timescale 1ns/10ps

module pgc_mac_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [11:0] i_len,
    input wire logic [11:0] i_rx_at,
    output logic o_tx_en,
    output logic o_rx_dv,
    output logic o_busy
);
    logic [11:0] byte_n;

    // Byte counter, one byte per clock; three idle bytes close a frame
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            byte_n <= 12'h000;
        end else if (i_start) begin
            byte_n <= 12'h001;
        end else if (byte_n != 12'h000 && byte_n <= i_len + 12'h002) begin
            byte_n <= byte_n + 12'h001;
        end else begin
            byte_n <= 12'h000;
        end
    end

    // Receive start lands on transmit byte i_rx_at, zero means none
    assign o_tx_en = (byte_n != 12'h000) && (byte_n <= i_len);
    assign o_rx_dv = (byte_n != 12'h000) && (i_rx_at != 12'h000) && (byte_n >= i_rx_at);
    assign o_busy = (byte_n != 12'h000);
endmodule

//--- tb/pgc_regs_tb.sv
// Self-checking bench for the general control and collision stats bank.
// Assumes one 100 MHz clock; mode straps start at SGMII to copper and change
// across a mid-run reset.
`timescale 1ns/10ps
`include "pgc_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module pgc_regs_tb;
    logic clk = 0, rst_n = 0, rd_s = 0, wr_s = 0, half = 1, link = 1, start = 0;
    logic [9:0] addr = 0;
    logic [31:0] wdata = 0, rd, rdata;
    logic [3:0] be = 4'hF;
    logic [2:0] pins = 3'h1, sys_mode;
    logic [11:0] len_s = 12'h010, at_s = 12'h000;
    logic [1:0] resp, rs;
    logic wait_s, tx_en, rx_dv, busy, sm_rst, sgmii_cu, snet, smac, cpref, irq;
    int n_fail = 0, n_tests = 0, seed = 49, drops = 0, p;
    int cnt[4] = '{0, 0, 0, 0};
    int lo[4] = '{65, 97, 129, 193};
    int w[4] = '{32, 32, 64, 40};
    int adjv[2] = '{0, 5};

    pgc_regs dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd_s),
        .i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_response(resp), .o_avs_waitrequest(wait_s), .i_half_duplex(half), .i_gmii_tx_en(tx_en),
        .i_gmii_rx_dv(rx_dv), .i_link_up(link), .i_mode_pins(pins), .o_phy_sm_rst(sm_rst),
        .o_sys_mode(sys_mode), .o_mode_sgmii_cu(sgmii_cu), .o_snoop_net(snet), .o_snoop_mac(smac),
        .o_copper_pref(cpref), .o_irq(irq));

    pgc_mac_model mac (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_len(len_s),
        .i_rx_at(at_s), .o_tx_en(tx_en), .o_rx_dv(rx_dv), .o_busy(busy));

    // 100 MHz core clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Reference bin of a receive start, -1 when before the window
    function automatic int bin_of(input int q, input int a);
        if (q >= 193 - a) return 3;
        if (q >= 129 - a) return 2;
        if (q >= 97 - a) return 1;
        if (q >= 65 - a) return 0;
        return -1;
    endfunction

    // One Avalon transfer, held until waitrequest is sampled low
    // No cycle count is assumed; only the watchdog ends a hung wait
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge clk);
        addr <= {idx, 2'b00};
        rd_s <= !wr;
        wr_s <= wr;
        wdata <= {16'h0000, wd};
        do begin
            @(posedge clk);
        end while (wait_s !== 1'b0);
        rd = rdata;
        rs = resp;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [15:0] ex);
        bus(1'b0, idx, 16'h0000);
        `CHK("readdata", {16'h0000, ex}, rd)
    endtask

    // One transmitted frame with a receive start at byte q
    task automatic frame(input int q, input int adj);
        int b;
        at_s <= q[11:0];
        len_s <= q[11:0] + 12'h004;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        do begin
            @(posedge clk);
        end while (busy !== 1'b0);
        repeat (2) @(posedge clk);
        b = bin_of(q, adj);
        if (half === 1'b1 && b >= 0 && cnt[b] < 255) cnt[b]++;
    endtask

    task automatic drop();
        link <= 1'b0;
        @(posedge clk);
        link <= 1'b1;
        @(posedge clk);
        if (drops < 255) drops++;
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(`PGC_IDX_GENCTL, 16'h0001);
        `CHK("sgmii_cu", 1'b1, sgmii_cu)
        rchk(`PGC_IDX_LC_HI, 16'h0000);
        // Mode change stays pending until a software reset
        bus(1'b1, `PGC_IDX_GENCTL, 16'h0002);
        rchk(`PGC_IDX_GENCTL, 16'h0002);
        `CHK("sys_mode", 3'h1, sys_mode)
        bus(1'b1, `PGC_IDX_GENCTL, 16'h8002);
        @(negedge clk);
        `CHK("sm_rst", 1'b1, sm_rst)
        rchk(`PGC_IDX_GENCTL, 16'h8002);
        repeat (8) @(posedge clk);
        rchk(`PGC_IDX_GENCTL, 16'h0002);
        `CHK("sys_mode", 3'h2, sys_mode)
        `CHK("sgmii_cu", 1'b0, sgmii_cu)
        bus(1'b1, `PGC_IDX_GENCTL, 16'h0001);
        bus(1'b1, `PGC_IDX_GENCTL, 16'h8001);
        repeat (8) @(posedge clk);
        `CHK("sgmii_cu", 1'b1, sgmii_cu)
        // Every snoop and media code
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, `PGC_IDX_GENCTL, 16'((k << 10) | (k << 4) | 1));
            @(posedge clk);
            @(negedge clk);
            `CHK("snoop_net", k == 2, snet)
            `CHK("snoop_mac", k == 3, smac)
            `CHK("copper_pref", k == 1, cpref)
            rchk(`PGC_IDX_GENCTL, 16'((k << 10) | (k << 4) | 1));
        end
        // Bin edges and random positions at two window settings
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, `PGC_IDX_WIN, {3'b000, adjv[j][4:0], 8'h00});
            frame(64 - adjv[j], adjv[j]);
            for (int b = 0; b < 4; b++) begin
                for (int k = 0; k < 3; k++) begin
                    p = lo[b] - adjv[j] + (k == 0 ? 0 : k == 1 ? w[b] - 1 : ($random(seed) & 255) % w[b]);
                    frame(p, adjv[j]);
                end
            end
            half <= 1'b0;
            frame(70, adjv[j]);
            half <= 1'b1;
            rchk(`PGC_IDX_LC_LO, {cnt[1][7:0], cnt[0][7:0]});
            rchk(`PGC_IDX_LC_HI, {cnt[3][7:0], cnt[2][7:0]});
            cnt = '{0, 0, 0, 0};
            rchk(`PGC_IDX_LC_LO, 16'h0000);
        end
        // Saturation at the earliest window
        bus(1'b1, `PGC_IDX_WIN, 16'h1F00);
        repeat (260) frame(34, 31);
        rchk(`PGC_IDX_LC_LO, 16'h00FF);
        cnt = '{0, 0, 0, 0};
        repeat (3) drop();
        rchk(`PGC_IDX_WIN, {8'h1F, drops[7:0]});
        drops = 0;
        repeat (258) drop();
        rchk(`PGC_IDX_WIN, {8'h1F, drops[7:0]});
        drops = 0;
        rchk(`PGC_IDX_WIN, 16'h1F00);
        // Interrupt: raised masked, enabled, cleared; unmapped and read-only places
        bus(1'b1, `PGC_IDX_IRQ_CLR, 16'h003F);
        bus(1'b1, `PGC_IDX_IRQ_EN, 16'h0000);
        drop();
        bus(1'b1, `PGC_IDX_IRQ_STAT, 16'h003F);
        rchk(`PGC_IDX_IRQ_STAT, 16'h0010);
        `CHK("irq", 1'b0, irq)
        bus(1'b1, `PGC_IDX_IRQ_EN, 16'h0010);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, `PGC_IDX_IRQ_CLR, 16'h0010);
        @(posedge clk);
        @(negedge clk);
        `CHK("irq", 1'b0, irq)
        bus(1'b0, 8'hFF, 16'h0000);
        `CHK("response", `PGC_RESP_DECERR, rs)
        `CHK("readdata", 32'h0000_0000, rd)
        // Mid-run reset with other straps, then a write with only the low byte enabled
        pins <= 3'h2;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(`PGC_IDX_GENCTL, 16'h0002);
        `CHK("sys_mode", 3'h2, sys_mode)
        be <= 4'h1;
        bus(1'b1, `PGC_IDX_GENCTL, 16'h8C22);
        be <= 4'hF;
        @(negedge clk);
        `CHK("sm_rst", 1'b0, sm_rst)
        rchk(`PGC_IDX_GENCTL, 16'h0022);
        print_verdict();
    end
endmodule
